// *** verilog/strap_pkg.sv ***
// Constants shared by the strap latch and status indicator block
package strap_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] REG_BASIC_ADDR = 8'h00;
  localparam logic [7:0] REG_SPECIAL_ADDR = 8'h1f;
  localparam logic [7:0] REG_IRQ_STATUS_ADDR = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK_ADDR = 8'h21;
  localparam logic [7:0] REG_STRAP_ADDR = 8'h22;
  localparam int SPEED_BIT = 13;
  localparam int AUTONEG_BIT = 12;
  localparam int DUPLEX_BIT = 8;
  localparam int INT_POL_BIT = 9;
  localparam logic [15:0] BASIC_WMASK = 16'h3100;
  localparam logic [15:0] SPECIAL_WMASK = 16'h0200;
  localparam logic [15:0] REG_ZERO = 16'h0000;
  localparam int STRAP_W = 10;
  localparam int ST_RMII = 0;
  localparam int ST_BTB = 1;
  localparam int ST_ADDR0 = 2;
  localparam int ST_SPEED = 3;
  localparam int ST_DUPLEX = 4;
  localparam int ST_AUTONEG = 5;
  localparam int ST_ADDR_HI = 6;
  localparam int ADDR_HI_W = 4;
  // Pull defaults: address 00001, LED pins pulled up, mode pins down
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 10'h03c;
  localparam int EV_W = 2;
  localparam int EV_LINK = 0;
  localparam int EV_PWRDN = 1;
  localparam logic [EV_W-1:0] EV_ZERO = 2'h0;
  localparam int RESET_MIN_NS = 50000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic {CAP_WAIT, CAP_HELD} cap_state_t;
endpackage : strap_pkg

// *** verilog/strap_capture.sv ***
// Samples strap levels once after reset release and holds them
module strap_capture
  import strap_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [strap_pkg::STRAP_W-1:0] pins,
  output logic [strap_pkg::STRAP_W-1:0] straps,
  output logic done
);
  typedef struct packed {
    cap_state_t st;
    logic [STRAP_W-1:0] val;
  } cap_regs_t;

  cap_regs_t r_q;
  cap_regs_t r_d;

  always_comb
  begin
    r_d = r_q;
    case (r_q.st)
      CAP_WAIT:
      begin
        // First edge after release; flops may not load ports in reset
        r_d.val = pins; // R14
        r_d.st = CAP_HELD;
      end
      CAP_HELD: r_d = r_q; // R14
      default: r_d.st = CAP_WAIT;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r_q.st <= CAP_WAIT;
      r_q.val <= STRAP_DEFAULT;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign straps = r_q.val;
  assign done = (r_q.st == CAP_HELD);
endmodule : strap_capture

// *** verilog/event_flags.sv ***
// Sticky event status with write-one-to-clear, mask and interrupt level
module event_flags
  import strap_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [strap_pkg::EV_W-1:0] events,
  input wire logic status_wr,
  input wire logic mask_wr,
  input wire logic [strap_pkg::EV_W-1:0] wdata,
  output logic [strap_pkg::EV_W-1:0] status,
  output logic [strap_pkg::EV_W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
  } ev_regs_t;

  ev_regs_t r_q;
  ev_regs_t r_d;
  logic [EV_W-1:0] status_nx;

  genvar i;
  generate
    for (i = 0; i < EV_W; i++)
    begin : g_bit
      // New event beats a same-cycle clear
      assign status_nx[i] = events[i] |
        (r_q.status[i] & ~(status_wr & wdata[i]));
    end
  endgenerate

  always_comb
  begin
    r_d = r_q;
    r_d.status = status_nx;
    if (mask_wr)
    begin
      r_d.mask = wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r_q.status <= EV_ZERO;
      r_q.mask <= EV_ZERO;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign status = r_q.status;
  assign mask = r_q.mask;
  assign irq = |(r_q.status & r_q.mask);
endmodule : event_flags

// *** verilog/strap_indicators.sv ***
// Strap latch, active-low status indicators and interrupt pin control
// Summary of operation
// R1: Strap pins input in reset, driven afterwards
// R2: Collision pin level selects reduced interface
// R3: Carrier pin level enables back-to-back mode
// R4: Interrupt pin polarity from register 1f bit 9
// R5: Interrupt pin level gives address bit zero
// R6: Link indicator low when link is up
// R7: Speed strap to bit 13; low means 100 (here a high strap sets speed_100)
// R8: Duplex strap to bit 8; low means full (here a high strap sets full_duplex)
// R9: Autoneg strap to bit 12; activity toggles
// R10: Power-down input active low
// R11: Unstrapped management address defaults to 00001
// R12: Reset held at least 50 us externally
// R13: Pulled-up level enables reduced interface mode
// R14: Straps registered at release, held until reset
//
// Decided for this implementation: the address map and the plain strobed port.
module strap_indicators
  import strap_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [strap_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [strap_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [strap_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic collision_pin_i,
  output logic collision_pin_o,
  output logic collision_pin_oe,
  input wire logic carrier_pin_i,
  output logic carrier_pin_o,
  output logic carrier_pin_oe,
  input wire logic int_pin_i,
  output logic int_pin_o,
  output logic int_pin_oe,
  input wire logic speed_pin_i,
  output logic speed_indicator_out,
  output logic speed_pin_oe,
  input wire logic duplex_pin_i,
  output logic duplex_indicator_out,
  output logic duplex_pin_oe,
  input wire logic activity_pin_i,
  output logic activity_indicator_out,
  output logic activity_pin_oe,
  output logic link_indicator_out,
  output logic link_pin_oe,
  input wire logic [strap_pkg::ADDR_HI_W-1:0] addr_hi_strap_i,
  input wire logic power_down_n,
  input wire logic link_up,
  input wire logic activity_pulse,
  input wire logic collision,
  input wire logic carrier_sense,
  output logic rmii_mode,
  output logic back_to_back_mode,
  output logic [4:0] mgmt_address,
  output logic power_down,
  output logic speed_100,
  output logic full_duplex,
  output logic autoneg_enable
);
  typedef struct packed {
    logic [DATA_W-1:0] basic;
    logic [DATA_W-1:0] special;
    logic [DATA_W-1:0] rdata;
    logic done_prev;
    logic link;
    logic pd;
    logic act;
    logic col_o;
    logic crs_o;
    logic int_o;
    logic link_o;
    logic speed_o;
    logic duplex_o;
    logic act_o;
  } top_regs_t;

  top_regs_t r_q;
  top_regs_t r_d;

  logic [STRAP_W-1:0] strap_pins;
  logic [STRAP_W-1:0] straps;
  logic cap_done;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_mask;
  logic ev_irq;
  logic status_wr;
  logic mask_wr;
  logic load_straps;
  logic int_active_high;

  // Strap sources; pins are inputs until capture completes
  always_comb
  begin
    strap_pins = STRAP_DEFAULT;
    strap_pins[ST_RMII] = collision_pin_i; // R2 R13
    strap_pins[ST_BTB] = carrier_pin_i; // R3
    strap_pins[ST_ADDR0] = int_pin_i; // R5
    strap_pins[ST_SPEED] = speed_pin_i; // R7
    strap_pins[ST_DUPLEX] = duplex_pin_i; // R8
    strap_pins[ST_AUTONEG] = activity_pin_i; // R9
    strap_pins[ST_ADDR_HI +: ADDR_HI_W] = addr_hi_strap_i;
  end

  strap_capture u_capture (
    .core_clk (core_clk),
    .rst (rst),
    .pins (strap_pins),
    .straps (straps),
    .done (cap_done)
  );

  assign status_wr = reg_wr & (reg_addr == REG_IRQ_STATUS_ADDR);
  assign mask_wr = reg_wr & (reg_addr == REG_IRQ_MASK_ADDR);
  assign events[EV_LINK] = cap_done & (link_up != r_q.link);
  assign events[EV_PWRDN] = cap_done & (~power_down_n != r_q.pd);

  event_flags u_events (
    .core_clk (core_clk),
    .rst (rst),
    .events (events),
    .status_wr (status_wr),
    .mask_wr (mask_wr),
    .wdata (reg_wdata[EV_W-1:0]),
    .status (ev_status),
    .mask (ev_mask),
    .irq (ev_irq)
  );

  assign load_straps = cap_done & ~r_q.done_prev;
  assign int_active_high = r_q.special[INT_POL_BIT];

  always_comb
  begin
    r_d = r_q;
    r_d.done_prev = cap_done;
    r_d.link = link_up;
    r_d.pd = ~power_down_n; // R10
    r_d.rdata = REG_ZERO;

    // Register writes; software may override the strapped values
    if (reg_wr && reg_addr == REG_BASIC_ADDR)
    begin
      r_d.basic = reg_wdata & BASIC_WMASK;
    end
    if (reg_wr && reg_addr == REG_SPECIAL_ADDR)
    begin
      r_d.special = reg_wdata & SPECIAL_WMASK; // R4
    end

    // Straps seed the control bits once per reset
    if (load_straps)
    begin
      r_d.basic[SPEED_BIT] = straps[ST_SPEED]; // R7
      r_d.basic[DUPLEX_BIT] = straps[ST_DUPLEX]; // R8
      r_d.basic[AUTONEG_BIT] = straps[ST_AUTONEG]; // R9
    end

    if (reg_rd)
    begin
      case (reg_addr)
        REG_BASIC_ADDR: r_d.rdata = r_q.basic;
        REG_SPECIAL_ADDR: r_d.rdata = r_q.special;
        REG_IRQ_STATUS_ADDR: r_d.rdata[EV_W-1:0] = ev_status;
        REG_IRQ_MASK_ADDR: r_d.rdata[EV_W-1:0] = ev_mask;
        REG_STRAP_ADDR: r_d.rdata[STRAP_W-1:0] = straps;
        default: r_d.rdata = REG_ZERO;
      endcase
    end

    // Activity toggles per traffic pulse; frozen in power-down
    if (activity_pulse && power_down_n)
    begin
      r_d.act = ~r_q.act; // R9
    end

    r_d.col_o = collision;
    r_d.crs_o = carrier_sense;
    // Pin polarity follows the polarity bit: active high when set, active low otherwise
    r_d.int_o = int_active_high ? ev_irq : ~ev_irq; // R4

    // Indicators are active low; power-down turns them all off
    if (!power_down_n)
    begin
      r_d.link_o = 1'b1; // R10
      r_d.speed_o = 1'b1;
      r_d.duplex_o = 1'b1;
      r_d.act_o = 1'b1;
    end
    else
    begin
      r_d.link_o = ~link_up; // R6
      r_d.speed_o = ~r_q.basic[SPEED_BIT]; // R7
      r_d.duplex_o = ~r_q.basic[DUPLEX_BIT]; // R8
      r_d.act_o = r_q.act; // R9
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r_q.basic <= REG_ZERO;
      r_q.special <= REG_ZERO;
      r_q.rdata <= REG_ZERO;
      r_q.done_prev <= 1'b0;
      r_q.link <= 1'b0;
      r_q.pd <= 1'b0;
      r_q.act <= 1'b1;
      r_q.col_o <= 1'b0;
      r_q.crs_o <= 1'b0;
      r_q.int_o <= 1'b1;
      r_q.link_o <= 1'b1;
      r_q.speed_o <= 1'b1;
      r_q.duplex_o <= 1'b1;
      r_q.act_o <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Output enables stay low through reset and the capture edge
  assign collision_pin_oe = cap_done; // R1
  assign carrier_pin_oe = cap_done; // R1
  assign int_pin_oe = cap_done; // R1
  assign speed_pin_oe = cap_done; // R1
  assign duplex_pin_oe = cap_done; // R1
  assign activity_pin_oe = cap_done; // R1
  assign link_pin_oe = cap_done; // R1

  assign collision_pin_o = r_q.col_o;
  assign carrier_pin_o = r_q.crs_o;
  assign int_pin_o = r_q.int_o;
  assign link_indicator_out = r_q.link_o;
  assign speed_indicator_out = r_q.speed_o;
  assign duplex_indicator_out = r_q.duplex_o;
  assign activity_indicator_out = r_q.act_o;

  assign reg_rdata = r_q.rdata;
  assign irq = ev_irq;

  assign rmii_mode = straps[ST_RMII]; // R2 R13 R14
  assign back_to_back_mode = straps[ST_BTB]; // R3 R14
  // Default pulls give address 00001 when nothing is strapped
  assign mgmt_address = {straps[ST_ADDR_HI +: ADDR_HI_W],
                         straps[ST_ADDR0]}; // R5 R11
  assign power_down = r_q.pd; // R10
  assign speed_100 = r_q.basic[SPEED_BIT];
  assign full_duplex = r_q.basic[DUPLEX_BIT];
  assign autoneg_enable = r_q.basic[AUTONEG_BIT];
endmodule : strap_indicators

// *** testbench/strap_indicators_props.sv ***
// Port checker for the strap latch and indicator block
module strap_indicators_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic collision_pin_oe,
  input wire logic collision_pin_i,
  input wire logic carrier_pin_i,
  input wire logic int_pin_i,
  input wire logic speed_pin_i,
  input wire logic duplex_pin_i,
  input wire logic activity_pin_i,
  input wire logic [strap_pkg::ADDR_HI_W-1:0] addr_hi_strap_i,
  input wire logic [4:0] mgmt_address,
  input wire logic rmii_mode,
  input wire logic back_to_back_mode,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic autoneg_enable,
  input wire logic link_up,
  input wire logic link_indicator_out,
  input wire logic activity_pulse,
  input wire logic activity_indicator_out,
  input wire logic power_down_n,
  input wire logic power_down
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_q;
  logic lit;
  // Edges since release, saturating
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end
  // Indicators mean nothing while loading or powered down
  assign lit = up_q == 2'h3 && !power_down;
  default clocking
    @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_OE_RELEASE: assert property (
    $fell(rst) |-> !collision_pin_oe ##1 collision_pin_oe)
    else $error("pin enable");
  AST_MODE_LATCH: assert property (
    $fell(rst) |=> {rmii_mode, back_to_back_mode} ==
      $past({collision_pin_i, carrier_pin_i}))
    else $error("mode strap");
  AST_ADDR_LATCH: assert property (
    $fell(rst) |=> mgmt_address == $past({addr_hi_strap_i, int_pin_i}))
    else $error("address strap");
  AST_REG0_LOAD: assert property (
    up_q == 2'h2 |-> {speed_100, full_duplex, autoneg_enable} ==
      $past({speed_pin_i, duplex_pin_i, activity_pin_i}, 2))
    else $error("basic load");
  AST_STRAP_HOLD: assert property (
    up_q == 2'h3 |-> $stable({rmii_mode, back_to_back_mode, mgmt_address}))
    else $error("strap moved");
  AST_LINK_LED: assert property (
    lit && $past(lit) |-> link_indicator_out == !$past(link_up))
    else $error("link led");
  AST_ACT_TOGGLE: assert property (
    lit && activity_pulse ##1 lit ##1 lit |-> $changed(activity_indicator_out))
    else $error("activity led");
  AST_PWRDN: assert property (
    up_q != 2'h0 |-> power_down == !$past(power_down_n))
    else $error("power down");
  COV_RMII: cover property ($fell(rst) ##1 rmii_mode);
  COV_ACT: cover property (lit && activity_pulse);
  COV_PWRDN: cover property ($rose(power_down));
endmodule : strap_indicators_props

bind strap_indicators strap_indicators_props props_i (.*);

// *** testbench/strap_board.sv ***
// Board strap resistors on the shared pins
module strap_board (
  input wire logic [9:0] levels,
  input wire logic [5:0] oe,
  input wire logic [5:0] drv,
  output logic [5:0] pin,
  output logic [3:0] addr_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pin falls to its resistor level
  assign pin = (oe & drv) | (~oe & levels[5:0]);
  assign addr_hi = levels[9:6];
endmodule : strap_board

// *** testbench/testbench.sv ***
// Self-checking bench for the strap latch and indicator block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import strap_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  // Write, read back: masks, read-only straps, unmapped hole
  row_t rows [7] = '{'{8'h00, 16'hffff, 16'h3100},
    '{8'h1f, 16'hffff, 16'h0200}, '{8'h21, 16'hffff, 16'h0003},
    '{8'h22, 16'hffff, 16'h0177}, '{8'h30, 16'hffff, 16'h0000},
    '{8'h1f, 16'h0000, 16'h0000}, '{8'h00, 16'h0000, 16'h0000}};
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic power_down_n = 1'b1, link_up = 1'b0, activity_pulse = 1'b0;
  logic collision = 1'b0, carrier_sense = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [9:0] levels = 10'h177;
  int err_count = 0, cmp_count = 0;
  wire [15:0] reg_rdata;
  wire [5:0] pin_i, drv, oe;
  wire [4:0] mgmt_address;
  wire [3:0] addr_hi;
  wire link_oe;
  wire irq, link_indicator_out, rmii_mode, back_to_back_mode, power_down;
  wire speed_100, full_duplex, autoneg_enable;
  strap_indicators dut (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .collision_pin_i(pin_i[0]), .collision_pin_o(drv[0]),
    .collision_pin_oe(oe[0]), .carrier_pin_i(pin_i[1]),
    .carrier_pin_o(drv[1]), .carrier_pin_oe(oe[1]), .int_pin_i(pin_i[2]),
    .int_pin_o(drv[2]), .int_pin_oe(oe[2]), .speed_pin_i(pin_i[3]),
    .speed_indicator_out(drv[3]), .speed_pin_oe(oe[3]),
    .duplex_pin_i(pin_i[4]), .duplex_indicator_out(drv[4]),
    .duplex_pin_oe(oe[4]), .activity_pin_i(pin_i[5]),
    .activity_indicator_out(drv[5]), .activity_pin_oe(oe[5]),
    .link_indicator_out, .link_pin_oe(link_oe), .addr_hi_strap_i(addr_hi),
    .power_down_n, .link_up, .activity_pulse, .collision,
    .carrier_sense, .rmii_mode, .back_to_back_mode, .mgmt_address,
    .power_down, .speed_100, .full_duplex, .autoneg_enable);
  strap_board board (.levels, .oe, .drv, .pin(pin_i), .addr_hi);
  always #50 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rdc
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial
  begin
    tick(4);
    chk({link_oe, oe}, 7'h00);
    @(posedge core_clk);
    rst <= 1'b0;
    tick(4);
    chk({link_oe, oe}, 7'h7f);
    chk(mgmt_address, 5'h0b);
    chk({rmii_mode, back_to_back_mode}, 2'b11);
    rdc(8'h00, 16'h1100);
    chk(drv[4:3], 2'b01);
    @(posedge core_clk);
    levels <= 10'h000;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    chk(drv[4:3], 2'b11);
    @(posedge core_clk);
    link_up <= 1'b1;
    activity_pulse <= 1'b1;
    collision <= 1'b1;
    @(posedge core_clk);
    activity_pulse <= 1'b0;
    tick(2);
    chk({irq, link_indicator_out, drv[5], drv[2]}, 4'h8);
    chk(drv[1:0], 2'b01);
    wr(8'h1f, 16'h0200);
    tick(2);
    chk(drv[2], 1'b1);
    rdc(8'h20, 16'h0001);
    wr(8'h20, 16'h0001);
    #1;
    chk(irq, 1'b0);
    wr(8'h21, 16'h0000);
    @(posedge core_clk);
    link_up <= 1'b0;
    carrier_sense <= 1'b1;
    tick(2);
    chk({irq, link_indicator_out}, 2'b01);
    chk(drv[1:0], 2'b11);
    rdc(8'h20, 16'h0001);
    wr(8'h00, 16'h2100);
    tick(3);
    chk(drv[4:3], 2'b00);
    @(posedge core_clk);
    power_down_n <= 1'b0;
    tick(3);
    chk({power_down, drv[5:3], link_indicator_out}, 5'h1f);
    rdc(8'h20, 16'h0003);
    @(posedge core_clk);
    power_down_n <= 1'b1;
    rst <= 1'b1;
    levels <= STRAP_DEFAULT;
    tick(2);
    chk({link_oe, oe}, 7'h00);
    repeat (RESET_MIN_CYC) @(posedge core_clk);
    rst <= 1'b0;
    tick(4);
    chk({rmii_mode, mgmt_address}, 6'h01);
    rdc(8'h22, {6'h00, STRAP_DEFAULT});
    rdc(8'h00, 16'h3100);
    test_done();
  end
  // Run needs well under a thousand cycles
  initial
  begin
    #200000;
    err_count++;
    test_done();
  end
endmodule : testbench
